// File: design/ifp_regs.svh
`ifndef IFP_REGS_SVH
`define IFP_REGS_SVH

// Special-function register addresses
`define IFP_ADDR_TMR_EXT_CTRL 8'h88
`define IFP_ADDR_EXT_FLAGS 8'h91
`define IFP_ADDR_SER0_CTRL 8'h98
`define IFP_ADDR_PEND_SUM_A 8'h9E
`define IFP_ADDR_PEND_SUM_B 8'h9F
`define IFP_ADDR_SER1_CTRL 8'hC0
`define IFP_ADDR_EXT_ENABLE 8'hE8
`define IFP_ADDR_EXT_PRIO 8'hF8

// Reset values
`define IFP_RST_BYTE 8'h00
`define IFP_RST_EXT6 6'h00
`define IFP_RST_FLAG5 5'h00

// Timer / external interrupt control fields, per channel stride
`define IFP_TC_SENSE_LSB 0
`define IFP_TC_FLAG_LSB 1
`define IFP_TC_RUN_LSB 4
`define IFP_TC_OVF_LSB 5
`define IFP_TC_STRIDE 2

// Serial control fields
`define IFP_SC_RX_FLAG 0
`define IFP_SC_TX_FLAG 1
`define IFP_SC_RX_NINTH 2
`define IFP_SC_TX_NINTH 3
`define IFP_SC_RX_EN 4
`define IFP_SC_MPROC 5
`define IFP_SC_MODE_LO 6
`define IFP_SC_MODE_HI 7

// Extended flag fields
`define IFP_EF_DMA 0
`define IFP_EF_PCA 1
`define IFP_EF_PERIPH 2
`define IFP_EF_SWDMA 3
`define IFP_EF_WAKE 4

// Pending summary fields
`define IFP_PS_FIRST_LSB 2
`define IFP_PS_SER2 0

// Widths
`define IFP_NUM_SRC 13
`define IFP_NUM_EXT 6
`define IFP_NUM_BASE 7
`define IFP_NUM_EFLAG 5
`define IFP_NUM_PSUM_A 6
`define IFP_EA_BIT 7

`endif

// File: design/ifp_pkg.sv
package ifp_pkg;

  // Interrupt sources in natural priority order, lowest code served first
  typedef enum logic [3:0] {
    SRC_EXT_A = 4'h0,
    SRC_TMR_A = 4'h1,
    SRC_EXT_B = 4'h2,
    SRC_TMR_B = 4'h3,
    SRC_SER0 = 4'h4,
    SRC_TMR_C = 4'h5,
    SRC_SER1 = 4'h6,
    SRC_DMA = 4'h7,
    SRC_PCA = 4'h8,
    SRC_PERIPH = 4'h9,
    SRC_SWDMA = 4'hA,
    SRC_WAKE = 4'hB,
    SRC_WDOG = 4'hC
  } ifp_src_t;

  // Serial operating modes
  typedef enum logic [1:0] {
    SER_MODE0 = 2'h0,
    SER_MODE1 = 2'h1,
    SER_MODE2 = 2'h2,
    SER_MODE3 = 2'h3
  } ifp_ser_mode_t;

endpackage : ifp_pkg

// File: design/ifp_arb_if.sv
`timescale 1ns/1ps
`include "ifp_regs.svh"

interface ifp_arb_if;
  logic [`IFP_NUM_SRC-1:0] pend;
  logic [`IFP_NUM_SRC-1:0] en;
  logic [`IFP_NUM_SRC-1:0] prio;
  logic gie;
  logic req;
  logic high;
  ifp_pkg::ifp_src_t src;

  modport ctrl (output pend, output en, output prio, output gie,
                input req, input high, input src);
  modport arb (input pend, input en, input prio, input gie,
               output req, output high, output src);
endinterface : ifp_arb_if

// File: design/ifp_arb.sv
`timescale 1ns/1ps
`include "ifp_regs.svh"

module ifp_arb (
  ifp_arb_if.arb a
);

  logic [`IFP_NUM_SRC-1:0] live_hi;
  logic [`IFP_NUM_SRC-1:0] live_lo;

  // Split enabled requests into the two priority groups
  for (genvar i = 0; i < `IFP_NUM_SRC; i++) begin : g_mask
    assign live_hi[i] = a.gie & a.en[i] & a.pend[i] & a.prio[i];
    assign live_lo[i] = a.gie & a.en[i] & a.pend[i] & ~a.prio[i];
  end

  // High group first, then lowest natural index; loop runs downward
  always_comb begin
    logic [`IFP_NUM_SRC-1:0] pick;
    pick = (|live_hi) ? live_hi : live_lo;
    a.src = ifp_pkg::SRC_EXT_A;
    for (int i = `IFP_NUM_SRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        a.src = ifp_pkg::ifp_src_t'(i[3:0]);
      end
    end
    a.req = |pick;
    a.high = |live_hi;
  end

endmodule : ifp_arb

// File: design/ifp_ctrl.sv
`timescale 1ns/1ps
`include "ifp_regs.svh"

// Summary of operation
// RULE1 - Interrupt bits in control register software writable; code writes only the overflow flags, not the pin flags
// RULE2 - Level mode flag follows pin, ignores writes
// RULE3 - Tick and wake flags ignore written ones
// RULE4 - Sense bit: one falling edge, zero low
// RULE5 - Pin flags read-only, cleared on vectoring; code clears them only in edge mode, in level mode the flag follows the pin
// RULE6 - Per-timer run bit starts or stops timer
// RULE7 - Overflow sets flag, vectoring clears it
// RULE8 - Serial done sets flags, software clears
// RULE9 - Ninth bit or stop bit captured by mode
// RULE10 - Written ninth bit sent in modes 2/3
// RULE11 - Reception accepted only while enabled
// RULE12 - Serial control holds multiprocessor and mode bits
// RULE13 - Extended enable bits 0-5, one enables
// RULE14 - Extended priority bits match, one is high
// RULE15 - Software should give DMA high priority
// RULE16 - DMA, counter, merged flags cleared on vectoring
// RULE17 - Software clears tick and wake flags
// RULE18 - Peripheral requests ORed onto shared line
// RULE19 - First summary reports six peripherals, bits 2-7
// RULE20 - Second summary reports third serial, bit 0
// RULE21 - Nothing reaches CPU without global enable
// RULE22 - High group first, then lowest natural number
module ifp_ctrl (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_RD_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic [1:0] EXT_IRQ_PIN_N_I,
  input wire logic [1:0] TIMER_OVF_I,
  input wire logic TIMER_C_FLAG_I,
  input wire logic [1:0] SER_RX_DONE_I,
  input wire logic [1:0] SER_TX_DONE_I,
  input wire logic [1:0] SER_RX_BIT9_I,
  input wire logic DMA_REQ_I,
  input wire logic PCA_REQ_I,
  input wire logic SWDMA_TICK_I,
  input wire logic WAKE_I,
  input wire logic WDOG_FLAG_I,
  input wire logic [5:0] PERIPH_PEND_I,
  input wire logic SER2_PEND_I,
  input wire logic [7:0] BASE_EN_I,
  input wire logic [6:0] BASE_PRIO_I,
  input wire logic VEC_ACK_I,
  input wire logic [3:0] VEC_ACK_SRC_I,
  output logic IRQ_REQ_O,
  output logic IRQ_HIGH_O,
  output logic [3:0] IRQ_SRC_O,
  output logic [1:0] TIMER_RUN_O,
  output logic [3:0] SER_MODE_O,
  output logic [1:0] SER_RX_EN_O,
  output logic [1:0] SER_MPROC_O,
  output logic [1:0] SER_TX_NINTH_O
);

  ifp_arb_if arb_bus ();

  logic [1:0] pin_q;
  logic [1:0] ext_sense;
  logic [1:0] ext_flag;
  logic [1:0] tmr_run;
  logic [1:0] tmr_ovf;
  logic [7:0] ser_reg [2];
  logic [`IFP_NUM_EXT-1:0] ext_en;
  logic [`IFP_NUM_EXT-1:0] ext_prio;
  logic [`IFP_NUM_EFLAG-1:0] eflag;
  logic [`IFP_NUM_PSUM_A-1:0] psum_a;
  logic psum_b;
  logic periph_line;
  logic [`IFP_NUM_SRC-1:0] ack_hit;
  logic wr_timer_ext_int_control;
  logic wr_eif;
  logic wr_eie;
  logic wr_eip;
  logic [1:0] wr_ser;

  ////////////////////////////////////////////////////////////////////////
  // Write decode and vector acknowledge

  assign wr_timer_ext_int_control = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_TMR_EXT_CTRL);
  assign wr_eif = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_EXT_FLAGS);
  assign wr_eie = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_EXT_ENABLE);
  assign wr_eip = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_EXT_PRIO);
  assign wr_ser[0] = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_SER0_CTRL);
  assign wr_ser[1] = SFR_WR_I && (SFR_ADDR_I == `IFP_ADDR_SER1_CTRL);

  // One-hot acknowledge; out-of-range codes hit nothing
  always_comb begin
    ack_hit = '0;
    if (VEC_ACK_I && (VEC_ACK_SRC_I < 4'(`IFP_NUM_SRC))) begin
      ack_hit[VEC_ACK_SRC_I] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External pins and timers, channel a then b

  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam int EXT_IDX = `IFP_TC_STRIDE * i;
    localparam int TMR_IDX = `IFP_TC_STRIDE * i + 1;

    // Previous pin sample for falling-edge detection
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        pin_q[i] <= 1'b1;
      end else begin
        pin_q[i] <= EXT_IRQ_PIN_N_I[i];
      end
    end

    // Sense select and run control are plain software bits
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        ext_sense[i] <= 1'b0;
        tmr_run[i] <= 1'b0;
      end else if (wr_timer_ext_int_control) begin
        // RULE4 sense select
        ext_sense[i] <= SFR_WDATA_I[`IFP_TC_SENSE_LSB + `IFP_TC_STRIDE * i];
        // RULE6 run control
        tmr_run[i] <= SFR_WDATA_I[`IFP_TC_RUN_LSB + `IFP_TC_STRIDE * i];
      end
    end

    // Pin flag never takes software writes
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        ext_flag[i] <= 1'b0;
      end else if (ext_sense[i]) begin
        // RULE5 vectoring clears, fresh edge wins
        ext_flag[i] <= (pin_q[i] & ~EXT_IRQ_PIN_N_I[i]) | (ext_flag[i] & ~ack_hit[EXT_IDX]);
      end else begin
        // RULE2 level mode follows pin
        ext_flag[i] <= ~EXT_IRQ_PIN_N_I[i];
      end
    end

    // Overflow flag: hardware set beats write or vector clear
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        tmr_ovf[i] <= 1'b0;
      end else if (TIMER_OVF_I[i]) begin
        // RULE7 overflow sets flag
        tmr_ovf[i] <= 1'b1;
      end else if (wr_timer_ext_int_control) begin
        // RULE1 software raise or cancel
        tmr_ovf[i] <= SFR_WDATA_I[`IFP_TC_OVF_LSB + `IFP_TC_STRIDE * i];
      end else if (ack_hit[TMR_IDX]) begin
        tmr_ovf[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial port control, port 0 then 1

  for (genvar p = 0; p < 2; p++) begin : g_ser
    logic [7:0] base;
    logic rx_take;
    logic ninth_take;
    ifp_pkg::ifp_ser_mode_t mode;

    assign base = wr_ser[p] ? SFR_WDATA_I : ser_reg[p];
    assign mode = ifp_pkg::ifp_ser_mode_t'({ser_reg[p][`IFP_SC_MODE_HI],
                                            ser_reg[p][`IFP_SC_MODE_LO]});
    // RULE11 gated by receive enable
    assign rx_take = SER_RX_DONE_I[p] & ser_reg[p][`IFP_SC_RX_EN];
    // RULE9 ninth bit in modes 2/3, stop bit in mode 1 with multiprocessor bit clear
    assign ninth_take = rx_take && ((mode == ifp_pkg::SER_MODE2) ||
                        (mode == ifp_pkg::SER_MODE3) ||
                        ((mode == ifp_pkg::SER_MODE1) && !ser_reg[p][`IFP_SC_MPROC]));

    // Completion sets beat software clears in the same cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        ser_reg[p] <= `IFP_RST_BYTE;
      end else begin
        // RULE12 mode and multiprocessor bits
        ser_reg[p] <= base;
        // RULE8 completion sets flags
        ser_reg[p][`IFP_SC_RX_FLAG] <= base[`IFP_SC_RX_FLAG] | rx_take;
        ser_reg[p][`IFP_SC_TX_FLAG] <= base[`IFP_SC_TX_FLAG] | SER_TX_DONE_I[p];
        if (ninth_take) begin
          ser_reg[p][`IFP_SC_RX_NINTH] <= SER_RX_BIT9_I[p];
        end
      end
    end

    assign SER_MODE_O[2*p +: 2] = {ser_reg[p][`IFP_SC_MODE_HI], ser_reg[p][`IFP_SC_MODE_LO]};
    assign SER_RX_EN_O[p] = ser_reg[p][`IFP_SC_RX_EN];
    assign SER_MPROC_O[p] = ser_reg[p][`IFP_SC_MPROC];
    // RULE10 ninth transmit bit to serializer
    assign SER_TX_NINTH_O[p] = ser_reg[p][`IFP_SC_TX_NINTH];
  end

  assign TIMER_RUN_O = tmr_run;

  ////////////////////////////////////////////////////////////////////////
  // Extended enable, priority, flags and peripheral summary

  // RULE13 extended enable and RULE14 extended priority
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ext_en <= `IFP_RST_EXT6;
      ext_prio <= `IFP_RST_EXT6;
    end else begin
      if (wr_eie) begin
        ext_en <= SFR_WDATA_I[`IFP_NUM_EXT-1:0];
      end
      if (wr_eip) begin
        ext_prio <= SFR_WDATA_I[`IFP_NUM_EXT-1:0];
      end
    end
  end

  // RULE18 merged line and RULE19 RULE20 summaries
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      periph_line <= 1'b0;
      psum_a <= '0;
      psum_b <= 1'b0;
    end else begin
      periph_line <= (|PERIPH_PEND_I) | SER2_PEND_I;
      psum_a <= PERIPH_PEND_I;
      psum_b <= SER2_PEND_I;
    end
  end

  // Read-only flags; the source holding high keeps them set
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eflag[`IFP_EF_PERIPH:`IFP_EF_DMA] <= '0;
    end else begin
      // RULE16 vector clears, set wins
      eflag[`IFP_EF_DMA] <= DMA_REQ_I | (eflag[`IFP_EF_DMA] & ~ack_hit[ifp_pkg::SRC_DMA]);
      eflag[`IFP_EF_PCA] <= PCA_REQ_I | (eflag[`IFP_EF_PCA] & ~ack_hit[ifp_pkg::SRC_PCA]);
      eflag[`IFP_EF_PERIPH] <= periph_line |
                               (eflag[`IFP_EF_PERIPH] & ~ack_hit[ifp_pkg::SRC_PERIPH]);
    end
  end

  // Tick and wake: software may only clear, vectoring leaves them alone
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eflag[`IFP_EF_WAKE:`IFP_EF_SWDMA] <= '0;
    end else begin
      // RULE3 written one ignored
      eflag[`IFP_EF_SWDMA] <= SWDMA_TICK_I |
                              (eflag[`IFP_EF_SWDMA] & ~(wr_eif & ~SFR_WDATA_I[`IFP_EF_SWDMA]));
      eflag[`IFP_EF_WAKE] <= WAKE_I |
                             (eflag[`IFP_EF_WAKE] & ~(wr_eif & ~SFR_WDATA_I[`IFP_EF_WAKE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration; DMA should be set high by software for best latency

  assign arb_bus.pend = {WDOG_FLAG_I, eflag, ser_reg[1][`IFP_SC_RX_FLAG] |
                         ser_reg[1][`IFP_SC_TX_FLAG], TIMER_C_FLAG_I,
                         ser_reg[0][`IFP_SC_RX_FLAG] | ser_reg[0][`IFP_SC_TX_FLAG],
                         tmr_ovf[1], ext_flag[1], tmr_ovf[0], ext_flag[0]};
  assign arb_bus.en = {ext_en, BASE_EN_I[`IFP_NUM_BASE-1:0]};
  assign arb_bus.prio = {ext_prio, BASE_PRIO_I};
  assign arb_bus.gie = BASE_EN_I[`IFP_EA_BIT];

  ifp_arb u_arb (
    .a (arb_bus.arb)
  );

  // RULE21 global gate and RULE22 ordering, registered to the core
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_REQ_O <= 1'b0;
      IRQ_HIGH_O <= 1'b0;
      IRQ_SRC_O <= 4'h0;
    end else begin
      IRQ_REQ_O <= arb_bus.req;
      IRQ_HIGH_O <= arb_bus.high;
      IRQ_SRC_O <= arb_bus.src;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency; unmapped addresses read zero

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SFR_RDATA_O <= `IFP_RST_BYTE;
    end else if (SFR_RD_I) begin
      unique case (SFR_ADDR_I)
        `IFP_ADDR_TMR_EXT_CTRL: SFR_RDATA_O <= {tmr_ovf[1], tmr_run[1], tmr_ovf[0],
                                                tmr_run[0], ext_flag[1], ext_sense[1],
                                                ext_flag[0], ext_sense[0]};
        `IFP_ADDR_EXT_FLAGS: SFR_RDATA_O <= 8'(eflag);
        `IFP_ADDR_SER0_CTRL: SFR_RDATA_O <= ser_reg[0];
        `IFP_ADDR_SER1_CTRL: SFR_RDATA_O <= ser_reg[1];
        `IFP_ADDR_PEND_SUM_A: SFR_RDATA_O <= {psum_a, 2'h0};
        `IFP_ADDR_PEND_SUM_B: SFR_RDATA_O <= 8'(psum_b);
        `IFP_ADDR_EXT_ENABLE: SFR_RDATA_O <= 8'(ext_en);
        `IFP_ADDR_EXT_PRIO: SFR_RDATA_O <= 8'(ext_prio);
        default: SFR_RDATA_O <= `IFP_RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  level_follow_a: assert property ( // RULE2
    !ext_sense[0] |=> ext_flag[0] == !$past(EXT_IRQ_PIN_N_I[0]))
    else $error("level-mode flag does not follow pin");
  edge_detect_a: assert property ( // RULE4
    ext_sense[0] && pin_q[0] && !EXT_IRQ_PIN_N_I[0] |=> ext_flag[0])
    else $error("falling edge missed");
  // Channel a is the one the edge-mode traffic vectors
  pin_ack_a: assert property ( // RULE5
    ext_sense[0] && ack_hit[ifp_pkg::SRC_EXT_A] && !(pin_q[0] && !EXT_IRQ_PIN_N_I[0])
    |=> !ext_flag[0])
    else $error("pin flag not cleared on vector");
  ovf_set_a: assert property (TIMER_OVF_I[1] |=> tmr_ovf[1] [*1] ##1 1'b1) // RULE7
    else $error("overflow flag not set");
  rx_gate_a: assert property ( // RULE11
    SER_RX_DONE_I[0] && !SER_RX_EN_O[0] && !wr_ser[0]
    |=> $stable(ser_reg[0][`IFP_SC_RX_FLAG]))
    else $error("reception taken while disabled");
  // Port 0 is the one the mode sweep exercises
  ninth_cap_a: assert property ( // RULE9
    g_ser[0].rx_take && SER_MODE_O[1]
    |=> ser_reg[0][`IFP_SC_RX_NINTH] == $past(SER_RX_BIT9_I[0]))
    else $error("ninth bit not captured");
  tick_wr1_a: assert property ( // RULE3
    wr_eif && !eflag[`IFP_EF_SWDMA] && !SWDMA_TICK_I |=> !eflag[`IFP_EF_SWDMA])
    else $error("written one set tick flag");
  summary_a: assert property ( // RULE19
    ##1 SFR_RD_I && SFR_ADDR_I == `IFP_ADDR_PEND_SUM_A
    |=> SFR_RDATA_O[7:2] == $past(PERIPH_PEND_I, 2))
    else $error("summary does not match pending lines");
  merged_line_a: assert property (SER2_PEND_I |-> ##2 eflag[`IFP_EF_PERIPH]) // RULE18
    else $error("merged request not raised");
  gie_gate_a: assert property (!BASE_EN_I[`IFP_EA_BIT] |=> !IRQ_REQ_O) // RULE21
    else $error("request without global enable");
  prio_order_a: assert property ( // RULE22
    arb_bus.req && arb_bus.high |-> arb_bus.prio[arb_bus.src])
    else $error("low group served over high group");

  cover_edge_c: cover property (ext_sense[0] ##1 ext_flag[0] ##[1:20] ack_hit[0]);
  cover_high_c: cover property (IRQ_REQ_O && IRQ_HIGH_O && IRQ_SRC_O == ifp_pkg::SRC_DMA);
  cover_ser_c: cover property (g_ser[0].ninth_take);
  cover_race_c: cover property (TIMER_OVF_I[0] && wr_timer_ext_int_control && !SFR_WDATA_I[`IFP_TC_OVF_LSB]);

endmodule : ifp_ctrl

// File: dv/ifp_cpu_model.sv
`timescale 1ns/1ps

module ifp_cpu_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ack_en_i,
  input wire logic irq_req_i,
  input wire logic [3:0] irq_src_i,
  output logic vec_ack_o,
  output logic [3:0] vec_src_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Vector taking, one pulse per request seen; no back-to-back pulses.
  // Idle source lines toggle so a stale code never looks valid.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vec_ack_o <= 1'b0;
      vec_src_o <= 4'h0;
    end else begin
      vec_ack_o <= #1 ack_en_i && irq_req_i && !vec_ack_o;
      vec_src_o <= #1 irq_req_i ? irq_src_i : ~vec_src_o;
    end
  end
endmodule : ifp_cpu_model

// File: dv/tb_ifp_ctrl.sv
`timescale 1ns/1ps

module tb_ifp_ctrl;
  logic CLK_I, RST_N_I, SFR_WR_I, SFR_RD_I, TIMER_C_FLAG_I, DMA_REQ_I, PCA_REQ_I;
  logic SWDMA_TICK_I, WAKE_I, WDOG_FLAG_I, SER2_PEND_I, VEC_ACK_I, IRQ_REQ_O, IRQ_HIGH_O;
  logic ack_en;
  logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O, BASE_EN_I;
  logic [1:0] EXT_IRQ_PIN_N_I, TIMER_OVF_I, SER_RX_DONE_I, SER_TX_DONE_I, SER_RX_BIT9_I;
  logic [1:0] TIMER_RUN_O, SER_RX_EN_O, SER_MPROC_O, SER_TX_NINTH_O;
  logic [5:0] PERIPH_PEND_I;
  logic [6:0] BASE_PRIO_I;
  logic [3:0] VEC_ACK_SRC_I, IRQ_SRC_O, SER_MODE_O;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  ifp_ctrl dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WR_I(SFR_WR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_RD_I(SFR_RD_I),
    .SFR_RDATA_O(SFR_RDATA_O), .EXT_IRQ_PIN_N_I(EXT_IRQ_PIN_N_I), .TIMER_OVF_I(TIMER_OVF_I),
    .TIMER_C_FLAG_I(TIMER_C_FLAG_I), .SER_RX_DONE_I(SER_RX_DONE_I),
    .SER_TX_DONE_I(SER_TX_DONE_I), .SER_RX_BIT9_I(SER_RX_BIT9_I), .DMA_REQ_I(DMA_REQ_I),
    .PCA_REQ_I(PCA_REQ_I), .SWDMA_TICK_I(SWDMA_TICK_I), .WAKE_I(WAKE_I),
    .WDOG_FLAG_I(WDOG_FLAG_I), .PERIPH_PEND_I(PERIPH_PEND_I), .SER2_PEND_I(SER2_PEND_I),
    .BASE_EN_I(BASE_EN_I), .BASE_PRIO_I(BASE_PRIO_I), .VEC_ACK_I(VEC_ACK_I),
    .VEC_ACK_SRC_I(VEC_ACK_SRC_I), .IRQ_REQ_O(IRQ_REQ_O), .IRQ_HIGH_O(IRQ_HIGH_O),
    .IRQ_SRC_O(IRQ_SRC_O), .TIMER_RUN_O(TIMER_RUN_O), .SER_MODE_O(SER_MODE_O),
    .SER_RX_EN_O(SER_RX_EN_O), .SER_MPROC_O(SER_MPROC_O), .SER_TX_NINTH_O(SER_TX_NINTH_O));

  ifp_cpu_model cpu (.clk_i(CLK_I), .rst_n_i(RST_N_I), .ack_en_i(ack_en),
    .irq_req_i(IRQ_REQ_O), .irq_src_i(IRQ_SRC_O), .vec_ack_o(VEC_ACK_I),
    .vec_src_o(VEC_ACK_SRC_I));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  // Hang guard; the sequence needs a few hundred cycles
  always @(posedge CLK_I) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs change one step after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    SFR_ADDR_I = a;
    SFR_WDATA_I = d;
    SFR_WR_I = 1'b1;
    tick(1);
    SFR_WR_I = 1'b0;
    // Idle edge so a following call never re-raises the strobe in this step
    tick(1);
  endtask : wr

  // Read data is registered at the taking edge
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    SFR_ADDR_I = a;
    SFR_RD_I = 1'b1;
    tick(1);
    SFR_RD_I = 1'b0;
    chk(nm, SFR_RDATA_O, exp);
    tick(1);
  endtask : rchk

  // Request seen by the core packed as {high, request, source}
  task automatic irq_chk(input string nm, input logic [7:0] exp);
    chk(nm, {2'h0, IRQ_HIGH_O, IRQ_REQ_O, IRQ_SRC_O}, exp);
  endtask : irq_chk

  task automatic rx_pulse(input logic b9);
    SER_RX_BIT9_I = {1'b0, b9};
    SER_RX_DONE_I = 2'h1;
    tick(1);
    SER_RX_DONE_I = 2'h0;
    tick(1);
  endtask : rx_pulse

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] addrs [9];
    addrs = '{8'h88, 8'h91, 8'h98, 8'h9E, 8'h9F, 8'hC0, 8'hE8, 8'hF8, 8'h90};
    {SFR_WR_I, SFR_RD_I, TIMER_C_FLAG_I, DMA_REQ_I, PCA_REQ_I, SWDMA_TICK_I} = 6'h00;
    {WAKE_I, WDOG_FLAG_I, SER2_PEND_I, ack_en} = 4'h0;
    {SFR_ADDR_I, SFR_WDATA_I, BASE_EN_I} = 24'h000000;
    {TIMER_OVF_I, SER_RX_DONE_I, SER_TX_DONE_I, SER_RX_BIT9_I} = 8'h00;
    PERIPH_PEND_I = 6'h00;
    BASE_PRIO_I = 7'h00;
    EXT_IRQ_PIN_N_I = 2'h3;
    RST_N_I = 1'b0;
    tick(12);
    RST_N_I = 1'b1;
    tick(1);
    foreach (addrs[i]) rchk("reset", addrs[i], 8'h00);
    $display("end of reset test");
    // Register access and control outputs
    wr(8'hE8, 8'hFF);
    rchk("ext_enable", 8'hE8, 8'h3F);
    wr(8'hF8, 8'hFF);
    rchk("ext_prio", 8'hF8, 8'h3F);
    wr(8'h9E, 8'hFF);
    rchk("summary_ro", 8'h9E, 8'h00);
    wr(8'h98, 8'hF8);
    rchk("ser0_ctrl", 8'h98, 8'hF8);
    chk("ser_outs", {SER_RX_EN_O[0], SER_MPROC_O[0], SER_TX_NINTH_O[0], 1'b0,
      SER_MODE_O}, 8'hE3);
    wr(8'h88, 8'h50);
    chk("run_both", {6'h0, TIMER_RUN_O}, 8'h03);
    wr(8'h88, 8'h10);
    chk("run_a", {6'h0, TIMER_RUN_O}, 8'h01);
    $display("end of register test");
    // Timer overflow, vectoring and global enable
    wr(8'hE8, 8'h00);
    wr(8'hF8, 8'h00);
    BASE_EN_I = 8'h82;
    ack_en = 1'b1;
    // Timer b overflows too but is not enabled, so its flag is never vectored
    TIMER_OVF_I = 2'h3;
    tick(1);
    TIMER_OVF_I = 2'h0;
    tick(1);
    irq_chk("timer_req", 8'h11);
    tick(4);
    rchk("timer_vec", 8'h88, 8'h90);
    irq_chk("timer_idle", 8'h00);
    ack_en = 1'b0;
    BASE_EN_I = 8'h02;
    wr(8'h88, 8'h30);
    tick(3);
    irq_chk("no_global", 8'h00);
    BASE_EN_I = 8'h82;
    tick(2);
    irq_chk("sw_raise", 8'h11);
    wr(8'h88, 8'h10);
    tick(2);
    irq_chk("sw_cancel", 8'h00);
    $display("end of timer test");
    // External pin a, level then edge sense
    BASE_EN_I = 8'h81;
    EXT_IRQ_PIN_N_I = 2'h2;
    tick(2);
    rchk("level_low", 8'h88, 8'h12);
    irq_chk("pin_req", 8'h10);
    EXT_IRQ_PIN_N_I = 2'h3;
    tick(2);
    wr(8'h88, 8'h12);
    tick(1);
    rchk("level_wr1", 8'h88, 8'h10);
    wr(8'h88, 8'h11);
    EXT_IRQ_PIN_N_I = 2'h2;
    tick(1);
    EXT_IRQ_PIN_N_I = 2'h3;
    tick(3);
    rchk("edge_held", 8'h88, 8'h13);
    ack_en = 1'b1;
    tick(5);
    rchk("edge_vec", 8'h88, 8'h11);
    $display("end of pin test");
    // Serial port 0: enable gate, capture by mode, software clear
    BASE_EN_I = 8'h90;
    wr(8'h98, 8'h80);
    rx_pulse(1'b1);
    rchk("rx_off", 8'h98, 8'h80);
    for (int m = 0; m < 4; m++) begin
      wr(8'h98, {m[1:0], 6'h10});
      rx_pulse(1'b1);
      rchk("rx_mode", 8'h98, {m[1:0], 6'h11} | ((m != 0) ? 8'h04 : 8'h00));
    end
    SER_TX_DONE_I = 2'h1;
    tick(1);
    SER_TX_DONE_I = 2'h0;
    tick(6);
    rchk("ser_kept", 8'h98, 8'hD7);
    wr(8'h98, 8'h00);
    rchk("ser_clear", 8'h98, 8'h00);
    $display("end of serial test");
    // Tick and wake flags
    BASE_EN_I = 8'h80;
    wr(8'hE8, 8'h18);
    wr(8'h91, 8'h18);
    rchk("tick_wr1", 8'h91, 8'h00);
    {SWDMA_TICK_I, WAKE_I} = 2'h3;
    tick(1);
    {SWDMA_TICK_I, WAKE_I} = 2'h0;
    tick(6);
    rchk("tick_set", 8'h91, 8'h18);
    irq_chk("tick_first", 8'h1A);
    wr(8'h91, 8'h10);
    rchk("tick_clr", 8'h91, 8'h10);
    wr(8'h91, 8'h00);
    tick(3);
    irq_chk("tick_idle", 8'h00);
    $display("end of tick test");
    // Merged peripheral line and summaries
    ack_en = 1'b0;
    wr(8'hE8, 8'h04);
    PERIPH_PEND_I = 6'h2A;
    SER2_PEND_I = 1'b1;
    tick(3);
    rchk("summary_a", 8'h9E, 8'hA8);
    rchk("summary_b", 8'h9F, 8'h01);
    rchk("merged", 8'h91, 8'h04);
    irq_chk("merged_req", 8'h19);
    PERIPH_PEND_I = 6'h00;
    SER2_PEND_I = 1'b0;
    ack_en = 1'b1;
    tick(6);
    rchk("merged_vec", 8'h91, 8'h00);
    $display("end of peripheral test");
    // Priority groups, PCA then left high over DMA
    ack_en = 1'b0;
    wr(8'hE8, 8'h03);
    wr(8'hF8, 8'h03);
    {DMA_REQ_I, PCA_REQ_I} = 2'h3;
    tick(1);
    {DMA_REQ_I, PCA_REQ_I} = 2'h0;
    tick(3);
    irq_chk("same_group", 8'h37);
    wr(8'hF8, 8'h02);
    tick(2);
    irq_chk("high_first", 8'h38);
    ack_en = 1'b1;
    tick(12);
    rchk("dma_pca_vec", 8'h91, 8'h00);
    $display("end of priority test");
    finish_test();
  end
endmodule : tb_ifp_ctrl
